/* cmp_ctrl_pkg.sv */
// Constants and register map for the analog comparator control block
//
// How it works
// - Threshold zero code drives level-zero DAC linearly
// - Threshold one code drives level-one DAC linearly
// - Flag D sets on enabled D output toggle
// - Flag C sets on enabled C output toggle
// - Flag B sets on enabled B output toggle
// - Flags cleared only by writing zero; toggle wins
// - Status bits 3..0 show live outputs, zero disabled
// - Shared B/C/D hysteresis select: none, 10mV, 20mV, 30mV
// - Comparator A hysteresis select: none, 10mV, 20mV, 30mV
// - Interrupt request when flag and enable set
// - Polarity bit inverts comparator output before use
// - Threshold select: level zero or external input
package cmp_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] IDX_STATUS = 32'h0000_0094;
	localparam logic [31:0] IDX_TH_ZERO = 32'h0000_a032;
	localparam logic [31:0] IDX_TH_ONE = 32'h0000_a033;
	localparam logic [31:0] IDX_CTRL = 32'h0000_0095;
	localparam logic [31:0] ADDR_STATUS = IDX_STATUS << 2;
	localparam logic [31:0] ADDR_TH_ZERO = IDX_TH_ZERO << 2;
	localparam logic [31:0] ADDR_TH_ONE = IDX_TH_ONE << 2;
	localparam logic [31:0] ADDR_CTRL = IDX_CTRL << 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_TH_CODE = 8'h00;
	localparam logic [15:0] RST_CTRL = 16'h0000;

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int STAT_FLAG_LSB = 4;
	localparam int STAT_LIVE_LSB = 0;
	localparam int STAT_HYS_BCD_LSB = 2;
	localparam int STAT_HYS_A_LSB = 0;

	// ----------------------------------------------------------------
	// Control register fields, one nibble per setting, bit n = comparator n
	// ----------------------------------------------------------------
	localparam int CTRL_EN_LSB = 0;
	localparam int CTRL_THSEL_LSB = 4;
	localparam int CTRL_POL_LSB = 8;
	localparam int CTRL_IRQEN_LSB = 12;

	// ----------------------------------------------------------------
	// Hysteresis codes and DAC scale
	// ----------------------------------------------------------------
	localparam logic [1:0] HYS_NONE = 2'h0;
	localparam logic [1:0] HYS_10MV = 2'h1;
	localparam logic [1:0] HYS_20MV = 2'h2;
	localparam logic [1:0] HYS_30MV = 2'h3;
	localparam int DAC_FULL_SCALE_MV = 1800;
	localparam logic [7:0] DAC_CODE_ZERO_V = 8'h00;
	localparam logic [7:0] DAC_CODE_FULL = 8'hff;

	// ----------------------------------------------------------------
	// AXI responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		HYS_SEL_NONE = 2'b00,
		HYS_SEL_10 = 2'b01,
		HYS_SEL_20 = 2'b10,
		HYS_SEL_30 = 2'b11
	} hys_sel_t;

endpackage : cmp_ctrl_pkg

/* cmp_input_sync.sv */
// Three-stage synchroniser with agreement filter for one comparator output
`timescale 1ns/1ps
`default_nettype none
module cmp_input_sync
	import cmp_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Raw level from analog core
	input wire logic raw_in,
	// Filtered level
	output logic stable_out
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic stable;
	} sync_state_t;

	sync_state_t st_ff;
	sync_state_t nxt_st;

	// Stable follows only when stages two and three agree
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = raw_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		if (st_ff.s2 == st_ff.s3) begin
			nxt_st.stable = st_ff.s3;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign stable_out = st_ff.stable;

endmodule : cmp_input_sync
`default_nettype wire

/* cmp_flag_cell.sv */
// Live output and sticky interrupt flag of one comparator
`timescale 1ns/1ps
`default_nettype none
module cmp_flag_cell
	import cmp_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Synchronised comparator level and settings
	input wire logic level_in,
	input wire logic enable,
	input wire logic invert,
	// Software write of the flag bit
	input wire logic flag_we,
	input wire logic flag_wval,
	// State
	output logic live_out,
	output logic flag_out
);

	typedef struct packed {
		logic live;
		logic en_d;
		logic flag;
	} cell_state_t;

	cell_state_t st_ff;
	cell_state_t nxt_st;
	logic live_now;
	logic toggle;

	// Polarity applied before status and flag; forced low when off
	assign live_now = enable & (level_in ^ invert);
	// Only a toggle seen across two enabled cycles counts
	assign toggle = enable & st_ff.en_d & (live_now != st_ff.live);

	// Set beats software clear in the same cycle
	always_comb begin
		nxt_st = st_ff;
		nxt_st.live = live_now;
		nxt_st.en_d = enable;
		if (flag_we) begin
			nxt_st.flag = flag_wval;
		end
		if (toggle) begin
			nxt_st.flag = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign live_out = st_ff.live;
	assign flag_out = st_ff.flag;

endmodule : cmp_flag_cell
`default_nettype wire

/* cmp_ctrl_top.sv */
// Analog comparator control: AXI4-Lite registers, flags and analog controls
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_top
	import cmp_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Comparator outputs from analog cores, index 0 = A .. 3 = D
	input wire logic [3:0] cmp_raw,
	// Threshold DAC codes
	output logic [7:0] threshold_level_zero,
	output logic [7:0] threshold_level_one,
	// Comparator settings toward analog cores
	output logic [3:0] cmp_enable,
	output logic [3:0] cmp_threshold_source,
	output logic [1:0] hysteresis_select_bcd,
	output logic [1:0] hysteresis_select_a,
	// Per-comparator interrupt requests
	output logic [3:0] cmp_irq_request
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic aw_have;
		logic [31:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] th_zero;
		logic [7:0] th_one;
		logic [1:0] hys_bcd;
		logic [1:0] hys_a;
		logic [3:0] en;
		logic [3:0] thsel;
		logic [3:0] pol;
		logic [3:0] irqen;
		logic [3:0] irq_req;
	} top_state_t;

	top_state_t st_ff;
	top_state_t nxt_st;

	// ----------------------------------------------------------------
	// Comparator paths
	// ----------------------------------------------------------------
	logic [3:0] level_sync;
	logic [3:0] live;
	logic [3:0] flags;
	logic do_write;
	logic wr_status;
	logic [3:0] flag_wval;

	// A write takes effect once both address and data are held
	// A new write waits while the last response is still unread
	assign do_write = st_ff.aw_have & st_ff.w_have & ~st_ff.bvalid;
	assign wr_status = do_write & (st_ff.aw_addr == ADDR_STATUS) & st_ff.w_strb[0];
	assign flag_wval = st_ff.w_data[STAT_FLAG_LSB +: 4];

	// One synchroniser and one flag cell per comparator
	// Flags sit in the cells so set-over-clear stays local to one bit
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_cmp
			cmp_input_sync u_sync (
				.aclk(aclk),
				.aresetn(aresetn),
				.raw_in(cmp_raw[gi]),
				.stable_out(level_sync[gi])
			);
			cmp_flag_cell u_cell (
				.aclk(aclk),
				.aresetn(aresetn),
				.level_in(level_sync[gi]),
				.enable(st_ff.en[gi]),
				.invert(st_ff.pol[gi]),
				.flag_we(wr_status),
				.flag_wval(flag_wval[gi]),
				.live_out(live[gi]),
				.flag_out(flags[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	logic [31:0] rd_data;
	logic rd_hit;

	// Unmapped reads return zero with a slave error
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			ADDR_STATUS: begin
				rd_data[STAT_FLAG_LSB +: 4] = flags;
				rd_data[STAT_LIVE_LSB +: 4] = live;
			end
			ADDR_TH_ZERO: begin
				rd_data[7:0] = st_ff.th_zero;
			end
			ADDR_TH_ONE: begin
				rd_data[7:0] = st_ff.th_one;
			end
			ADDR_CTRL: begin
				rd_data[CTRL_EN_LSB +: 4] = st_ff.en;
				rd_data[CTRL_THSEL_LSB +: 4] = st_ff.thsel;
				rd_data[CTRL_POL_LSB +: 4] = st_ff.pol;
				rd_data[CTRL_IRQEN_LSB +: 4] = st_ff.irqen;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	logic wr_hit;

	// Decode of the held write address; a miss answers with an error
	always_comb begin
		case (st_ff.aw_addr)
			ADDR_STATUS: wr_hit = 1'b1;
			ADDR_TH_ZERO: wr_hit = 1'b1;
			ADDR_TH_ONE: wr_hit = 1'b1;
			ADDR_CTRL: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;

		// Capture address and data independently, in either order
		if (s_axi_awvalid && st_ff.awready) begin
			nxt_st.aw_have = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_ff.wready) begin
			nxt_st.w_have = 1'b1;
			nxt_st.w_data = s_axi_wdata;
			nxt_st.w_strb = s_axi_wstrb;
		end

		// Retire the response once the master takes it
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end

		// Perform the write and raise the response
		if (do_write) begin
			nxt_st.aw_have = 1'b0;
			nxt_st.w_have = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
			if (st_ff.w_strb[0]) begin
				case (st_ff.aw_addr)
					ADDR_STATUS: begin
						// Flags are handled in the cells; low nibble holds selects
						nxt_st.hys_bcd = st_ff.w_data[STAT_HYS_BCD_LSB +: 2];
						nxt_st.hys_a = st_ff.w_data[STAT_HYS_A_LSB +: 2];
					end
					ADDR_TH_ZERO: begin
						nxt_st.th_zero = st_ff.w_data[7:0];
					end
					ADDR_TH_ONE: begin
						nxt_st.th_one = st_ff.w_data[7:0];
					end
					ADDR_CTRL: begin
						nxt_st.en = st_ff.w_data[CTRL_EN_LSB +: 4];
						nxt_st.thsel = st_ff.w_data[CTRL_THSEL_LSB +: 4];
					end
					default: begin
						nxt_st.en = st_ff.en;
					end
				endcase
			end
			if (st_ff.w_strb[1] && (st_ff.aw_addr == ADDR_CTRL)) begin
				nxt_st.pol = st_ff.w_data[CTRL_POL_LSB +: 4];
				nxt_st.irqen = st_ff.w_data[CTRL_IRQEN_LSB +: 4];
			end
		end

		// Ready only while the holding slot is free
		nxt_st.awready = ~nxt_st.aw_have;
		nxt_st.wready = ~nxt_st.w_have;

		// Read channel: one outstanding read at a time
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_ff.arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd_data;
			nxt_st.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		nxt_st.arready = ~nxt_st.rvalid;

		// Request follows the flag one cycle later
		nxt_st.irq_req = flags & st_ff.irqen;
	end

	// ----------------------------------------------------------------
	// Register the state
	// ----------------------------------------------------------------
	// Reset values kept in one place; constants only, nothing sampled
	function automatic top_state_t reset_state();
		top_state_t s;
		s = '0;
		// Slots free, so a request may be taken at the first edge out of reset
		s.awready = 1'b1;
		s.wready = 1'b1;
		s.arready = 1'b1;
		// Both responses idle at okay
		s.bresp = RESP_OKAY;
		s.rresp = RESP_OKAY;
		// DAC codes at zero volts, which is also the low-power setting
		s.th_zero = RST_TH_CODE;
		s.th_one = RST_TH_CODE;
		// Hysteresis selects take the status register reset value
		s.hys_bcd = RST_STATUS[STAT_HYS_BCD_LSB +: 2];
		s.hys_a = RST_STATUS[STAT_HYS_A_LSB +: 2];
		// Comparators off, no inversion, no interrupt; flags live in the cells
		s.en = RST_CTRL[CTRL_EN_LSB +: 4];
		s.thsel = RST_CTRL[CTRL_THSEL_LSB +: 4];
		s.pol = RST_CTRL[CTRL_POL_LSB +: 4];
		s.irqen = RST_CTRL[CTRL_IRQEN_LSB +: 4];
		return s;
	endfunction : reset_state

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= reset_state();
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from flops
	// ----------------------------------------------------------------
	// Bus handshake and response outputs
	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready = st_ff.wready;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	// DAC scales linearly, code 00 is 0 V and code ff is full scale
	assign threshold_level_zero = st_ff.th_zero;
	assign threshold_level_one = st_ff.th_one;
	assign cmp_enable = st_ff.en;
	// Clear picks level zero, set picks the external threshold pin
	assign cmp_threshold_source = st_ff.thsel;
	// Codes 00 none, 01 10mV, 10 20mV, 11 30mV
	assign hysteresis_select_bcd = st_ff.hys_bcd;
	assign hysteresis_select_a = st_ff.hys_a;
	assign cmp_irq_request = st_ff.irq_req;

endmodule : cmp_ctrl_top
`default_nettype wire

/* cmp_ctrl_properties.sv */
// Port-level checks of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_properties
	import cmp_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog controls
	input wire logic [7:0] threshold_level_zero,
	input wire logic [7:0] threshold_level_one,
	input wire logic [1:0] hysteresis_select_bcd,
	input wire logic [1:0] hysteresis_select_a,
	input wire logic [3:0] cmp_irq_request
);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wr_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	rd_data_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	wr_slot_free_a: assert property ($rose(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
		else $error("write slot not freed with response");
	rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read ready during response");
	thr_by_write_a: assert property (
		!$stable({threshold_level_zero, threshold_level_one}) |-> $rose(s_axi_bvalid))
		else $error("threshold code moved without write");
	hys_by_write_a: assert property (
		!$stable({hysteresis_select_bcd, hysteresis_select_a}) |-> $rose(s_axi_bvalid))
		else $error("hysteresis moved without write");
	irq_sticky_a: assert property (
		|($past(cmp_irq_request) & ~cmp_irq_request) |-> $past(s_axi_bvalid)
		|| $past(s_axi_bvalid, 2)) else $error("request cleared without write");

	// Main scenarios reached
	cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($rose(cmp_irq_request[3]));
endmodule : cmp_ctrl_properties

bind cmp_ctrl_top cmp_ctrl_properties u_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.threshold_level_zero(threshold_level_zero),
	.threshold_level_one(threshold_level_one),
	.hysteresis_select_bcd(hysteresis_select_bcd),
	.hysteresis_select_a(hysteresis_select_a),
	.cmp_irq_request(cmp_irq_request)
);
`default_nettype wire

/* cmp_analog_model.sv */
// Behavioural analog comparator cores and threshold DAC
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model
	import cmp_ctrl_pkg::*;
(
	// Settings from the control block
	input wire logic [7:0] threshold_level_zero,
	input wire logic [3:0] cmp_threshold_source,
	// Analog inputs in mV, 12 bits per comparator
	input wire logic [47:0] vin_mv,
	input wire logic [11:0] ext_mv,
	// Comparator levels
	output logic [3:0] cmp_raw
);
	int th_mv;

	// Linear DAC, code 0x00 is 0V and 0xff full scale
	assign th_mv = int'(threshold_level_zero) * DAC_FULL_SCALE_MV / 255;

	// No hysteresis modelled: inputs never dwell near the trip point
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			cmp_raw[i] = (cmp_threshold_source[i] ? int'(ext_mv) : th_mv)
				< int'(vin_mv[i*12 +: 12]);
		end
	end
endmodule : cmp_analog_model
`default_nettype wire

/* analog_comparator_control_tb_top.sv */
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_control_tb_top
	import cmp_ctrl_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, hysteresis_select_bcd, hysteresis_select_a;
	logic [31:0] s_axi_rdata;
	logic [3:0] cmp_raw, cmp_enable, cmp_threshold_source, cmp_irq_request;
	logic [7:0] threshold_level_zero, threshold_level_one;
	logic [47:0] vin_mv = '0;
	logic [11:0] ext_mv = '0;
	logic [15:0] hys_codes = 16'h3e94;
	int bad_count = 0;
	int n_compared = 0;

	typedef struct {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [31:0] rexp;
		logic [1:0] resp;
	} row_t;
	// Plain register accesses; the last row leaves threshold zero mid-scale
	row_t rows[5] = '{
		'{ADDR_TH_ZERO, 32'h0000_00ff, 32'h0000_00ff, RESP_OKAY},
		'{ADDR_TH_ONE, 32'hffff_ff5a, 32'h0000_005a, RESP_OKAY},
		'{ADDR_TH_ONE, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
		'{32'h0000_0258, 32'h0000_0011, 32'h0000_0000, RESP_SLVERR},
		'{ADDR_TH_ZERO, 32'h0000_0080, 32'h0000_0080, RESP_OKAY}
	};

	cmp_ctrl_top u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.cmp_raw(cmp_raw),
		.threshold_level_zero(threshold_level_zero),
		.threshold_level_one(threshold_level_one),
		.cmp_enable(cmp_enable), .cmp_threshold_source(cmp_threshold_source),
		.hysteresis_select_bcd(hysteresis_select_bcd),
		.hysteresis_select_a(hysteresis_select_a),
		.cmp_irq_request(cmp_irq_request)
	);
	cmp_analog_model u_cores (
		.threshold_level_zero(threshold_level_zero),
		.cmp_threshold_source(cmp_threshold_source),
		.vin_mv(vin_mv), .ext_mv(ext_mv), .cmp_raw(cmp_raw)
	);

	// 100 ns clock
	initial begin
		forever #50 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		if (bad_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim

	// Address and data offered together, each released once taken
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				s_axi_bready <= 1'b0;
				chk(32'(s_axi_bresp), 32'(r));
				@(posedge aclk);
				return;
			end
		end
		bad_count++;
		end_sim();
	endtask : axi_wr

	// Read and compare data and response
	task automatic axi_rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				s_axi_rready <= 1'b0;
				chk(s_axi_rdata, e);
				chk(32'(s_axi_rresp), 32'(r));
				@(posedge aclk);
				return;
			end
		end
		bad_count++;
		end_sim();
	endtask : axi_rd

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (rows[i]) begin
			axi_wr(rows[i].addr, rows[i].wdata, rows[i].resp);
			axi_rd(rows[i].addr, rows[i].rexp, rows[i].resp);
		end
		chk(32'(threshold_level_zero), 32'h0000_0080);
		chk(32'(threshold_level_one), 32'h0000_0000);
		// Every hysteresis code on both fields, fields differing
		for (int c = 0; c < 4; c++) begin
			axi_wr(ADDR_STATUS, 32'(hys_codes[c*4 +: 4]), RESP_OKAY);
			chk({28'h0, hysteresis_select_bcd, hysteresis_select_a},
				32'(hys_codes[c*4 +: 4]));
		end
		// Enable all four with interrupts; quiet inputs give no flag
		axi_wr(ADDR_CTRL, 32'h0000_f00f, RESP_OKAY);
		chk(32'(cmp_enable), 32'h0000_000f);
		repeat (12) @(posedge aclk);
		axi_rd(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
		// Raise each input in turn; earlier flags must stay set
		for (int i = 0; i < 4; i++) begin
			vin_mv[i*12 +: 12] <= 12'h5dc;
			for (int n = 0; n < 30 && cmp_irq_request[i] !== 1'b1; n++) @(posedge aclk);
			chk(32'(cmp_irq_request), 32'((2 << i) - 1));
			axi_rd(ADDR_STATUS, 32'(((2 << i) - 1) * 8'h11), RESP_OKAY);
		end
		// Software clear of all flags
		axi_wr(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
		repeat (2) @(posedge aclk);
		axi_rd(ADDR_STATUS, 32'h0000_000f, RESP_OKAY);
		chk(32'(cmp_irq_request), 32'h0000_0000);
		// Invert A while enabled: live drops, flag sets
		axi_wr(ADDR_CTRL, 32'h0000_f10f, RESP_OKAY);
		repeat (12) @(posedge aclk);
		axi_rd(ADDR_STATUS, 32'h0000_001e, RESP_OKAY);
		// B onto the external threshold above its input
		ext_mv <= 12'h7d0;
		axi_wr(ADDR_CTRL, 32'h0000_f12f, RESP_OKAY);
		chk(32'(cmp_threshold_source), 32'h0000_0002);
		repeat (12) @(posedge aclk);
		axi_rd(ADDR_STATUS, 32'h0000_003c, RESP_OKAY);
		// Disabled: live forced low, toggles ignored, flags kept
		axi_wr(ADDR_CTRL, 32'h0000_f020, RESP_OKAY);
		vin_mv[35:24] <= 12'h000;
		repeat (12) @(posedge aclk);
		axi_rd(ADDR_STATUS, 32'h0000_0030, RESP_OKAY);
		chk(32'(cmp_irq_request), 32'h0000_0003);
		// Reset in mid-run returns everything to its reset value
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({29'h0, s_axi_awready, s_axi_wready, s_axi_arready}, 32'h0000_0007);
		chk({8'h00, threshold_level_zero, threshold_level_one, cmp_enable, cmp_irq_request},
			32'h0000_0000);
		axi_rd(ADDR_TH_ZERO, 32'h0000_0000, RESP_OKAY);
		axi_rd(ADDR_TH_ONE, 32'h0000_0000, RESP_OKAY);
		axi_rd(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
		axi_rd(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
		end_sim();
	end
endmodule : analog_comparator_control_tb_top
`default_nettype wire
